/* File: verilog/ptg_pkg.sv */
package ptg_pkg;

  // Panel data formats served by the timing generator
  typedef enum logic [1:0] {
    PTG_MONO8,
    PTG_COLOR4,
    PTG_COLOR8_F1,
    PTG_COLOR8_F2
  } ptg_mode_e;

  // Widths of programmed fields, position counters and data pins, and the FIFO depth
  localparam int PTG_HFIELD_W = 7;
  localparam int PTG_POS_FIELD_W = 10;
  localparam int PTG_POS_W = 11;
  localparam int PTG_AC_W = 6;
  localparam int PTG_DATA_W = 8;
  localparam int PTG_FIFO_DEPTH = 4;

  // Field to count conversions
  localparam logic [10:0] PTG_FIELD_ADD = 11'h001;
  localparam int PTG_HUNIT_SHIFT = 3;
  localparam logic [10:0] PTG_ACTIVE_START_OFFSET_ADD = 11'h016;

  // Shift clock shapes, in pixel clocks from the active start
  localparam logic [2:0] PTG_MONO8_HIGH = 3'h4;
  localparam logic [10:0] PTG_C4_LEAD = 11'h001;

  // Reset value of the data pins, and the bias setting that selects one toggle per frame
  localparam logic [7:0] PTG_DATA_RESET = 8'h00;
  localparam logic [5:0] PTG_AC_PER_FRAME = 6'h00;

endpackage : ptg_pkg

/* File: verilog/ptg_stream_if.sv */
`timescale 1ns/1ps
interface ptg_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ptg_stream_if

/* File: verilog/ptg_fifo.sv */
`timescale 1ns/1ps
module ptg_fifo
  import ptg_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Filling side
  ptg_stream_if.snk fill,
  // Draining side
  ptg_stream_if.src drain
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("ptg_fifo: DEPTH must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
  } ptg_fifo_s;

  ptg_fifo_s r_reg;
  ptg_fifo_s r_next;
  logic push;
  logic pop;

  assign fill.ready = r_reg.in_rdy;
  assign drain.valid = (r_reg.cnt != '0);
  assign drain.data = r_reg.mem[r_reg.rp];

  always_comb
  begin
    r_next = r_reg;
    push = fill.valid && r_reg.in_rdy;
    pop = drain.ready && (r_reg.cnt != '0);
    if (push)
    begin
      r_next.mem[r_reg.wp] = fill.data;
      r_next.wp = (r_reg.wp == LAST_C) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop)
    begin
      r_next.rp = (r_reg.rp == LAST_C) ? '0 : r_reg.rp + 1'b1;
    end
    if (push && !pop)
    begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    // Registered ready keeps the upstream path short
    r_next.in_rdy = (r_next.cnt < DEPTH_C);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

endmodule : ptg_fifo

/* File: verilog/ptg_timing_gen.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Active lines are field plus one
// - Blank lines are total minus active
// - Active pixels are field plus one, times eight
// - Blank pixels are total minus active pixels
// - Horizontal timing counted in whole pixel clocks
// - Frame pulse leads line fall by start+width
// - Frame pulse holds total minus start+width
// - Bias toggle leads line rise by start
// - Last shift fall placed by mode offset
// - Format one ends two shift clocks apart
// - Shift-to-line-fall adds line pulse width
// - First shift rise after active start offset
// - First shift fall after mode delay
// - Mono shift: period eight, four low/high
// - Colour four: one pixel, half phases
// - Format one: two clocks, period four
// - Format two: period two, one low/high
// - Pixels per line are field plus one, eight
// - Line pulse starts at field plus one
// - Line pulse width is field plus one
// - Active start is field plus twenty-two
module ptg_timing_gen
  import ptg_pkg::*;
#(
  parameter int FIFO_DEPTH = PTG_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Pixel clock from outside, sampled
  input wire logic pixel_clock,
  // Control and timing fields
  input wire logic enable,
  input wire ptg_mode_e mode,
  input wire logic [PTG_HFIELD_W-1:0] pixels_per_line_cfg,
  input wire logic [PTG_HFIELD_W-1:0] active_pixels_per_line_cfg,
  input wire logic [PTG_POS_FIELD_W-1:0] active_start_offset_cfg,
  input wire logic [PTG_POS_FIELD_W-1:0] line_pulse_start_cfg,
  input wire logic [PTG_HFIELD_W-1:0] line_pulse_width_cfg,
  input wire logic [PTG_POS_FIELD_W-1:0] lines_per_frame_cfg,
  input wire logic [PTG_POS_FIELD_W-1:0] active_lines_per_frame_cfg,
  input wire logic [PTG_AC_W-1:0] ac_bias_lines_cfg,
  // Pixel data stream
  input wire logic [PTG_DATA_W-1:0] pix_data,
  input wire logic pix_valid,
  output logic pix_ready,
  // Panel pins
  output logic frame_pulse,
  output logic line_pulse,
  output logic shift_clock,
  output logic second_shift_clock,
  output logic [PTG_DATA_W-1:0] panel_data_bus,
  output logic ac_bias_toggle,
  // Status
  output logic underrun
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("ptg_timing_gen: FIFO_DEPTH must be at least 2");
  end

  typedef struct packed {
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_s3;
    logic [PTG_POS_W-1:0] h;
    logic [PTG_POS_W-1:0] v;
    logic line;
    logic frame;
    logic sh;
    logic sh2;
    logic ac;
    logic [PTG_AC_W-1:0] ac_cnt;
    logic [PTG_DATA_W-1:0] dat;
    logic underrun;
    logic [PTG_POS_W-1:0] lcnt;
    logic [PTG_POS_W-1:0] fcnt;
    logic [PTG_POS_W-1:0] scnt;
    logic line_seen;
  } ptg_state_s;

  ptg_state_s r_reg;
  ptg_state_s r_next;

  ptg_stream_if #(.W(PTG_DATA_W)) in_s ();
  ptg_stream_if #(.W(PTG_DATA_W)) out_s ();

  ptg_fifo #(
    .W(PTG_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .fill(in_s),
    .drain(out_s)
  );

  logic [PTG_POS_W-1:0] ht;
  logic [PTG_POS_W-1:0] active_pixels_per_line;
  logic [PTG_POS_W-1:0] active_start_offset;
  logic [PTG_POS_W-1:0] line_pulse_start;
  logic [PTG_POS_W-1:0] line_pulse_width;
  logic [PTG_POS_W-1:0] vt;
  logic [PTG_POS_W-1:0] active_lines_per_frame;
  logic rise;
  logic fall;
  logic [PTG_POS_W-1:0] h_nx;
  logic [PTG_POS_W-1:0] v_nx;
  logic [PTG_POS_W-1:0] rel;
  logic active;
  logic load;
  logic pop;

  // Totals and positions from the programmed fields
  assign ht = PTG_POS_W'(({4'h0, pixels_per_line_cfg} + PTG_FIELD_ADD)
    << PTG_HUNIT_SHIFT);
  assign active_pixels_per_line = PTG_POS_W'(({4'h0, active_pixels_per_line_cfg}
    + PTG_FIELD_ADD) << PTG_HUNIT_SHIFT);
  assign active_start_offset = {1'b0, active_start_offset_cfg} + PTG_ACTIVE_START_OFFSET_ADD;
  assign line_pulse_start = {1'b0, line_pulse_start_cfg} + PTG_FIELD_ADD;
  assign line_pulse_width = {4'h0, line_pulse_width_cfg} + PTG_FIELD_ADD;
  assign vt = {1'b0, lines_per_frame_cfg} + PTG_FIELD_ADD;
  assign active_lines_per_frame = {1'b0, active_lines_per_frame_cfg} + PTG_FIELD_ADD;

  // Edges seen only past the second sampling stage
  assign rise = r_reg.pclk_s2 && !r_reg.pclk_s3;
  assign fall = !r_reg.pclk_s2 && r_reg.pclk_s3;

  assign in_s.valid = pix_valid;
  assign in_s.data = pix_data;
  assign pix_ready = in_s.ready;
  assign out_s.ready = pop;

  assign frame_pulse = r_reg.frame;
  assign line_pulse = r_reg.line;
  assign shift_clock = r_reg.sh;
  assign second_shift_clock = r_reg.sh2;
  assign panel_data_bus = r_reg.dat;
  assign ac_bias_toggle = r_reg.ac;
  assign underrun = r_reg.underrun;

  always_comb
  begin
    r_next = r_reg;
    pop = 1'b0;
    load = 1'b0;
    h_nx = r_reg.h;
    v_nx = r_reg.v;
    rel = '0;
    active = 1'b0;
    r_next.pclk_s1 = pixel_clock;
    r_next.pclk_s2 = r_reg.pclk_s1;
    r_next.pclk_s3 = r_reg.pclk_s2;
    if (!enable)
    begin
      // Parked on the last pixel so the first tick opens line zero
      r_next.h = ht - PTG_FIELD_ADD;
      r_next.v = vt - PTG_FIELD_ADD;
      r_next.line = 1'b0;
      r_next.frame = 1'b0;
      r_next.sh = 1'b0;
      r_next.sh2 = 1'b0;
      r_next.ac = 1'b0;
      r_next.ac_cnt = '0;
      r_next.dat = PTG_DATA_RESET;
      r_next.underrun = 1'b0;
      r_next.line_seen = 1'b0;
    end
    else if (rise)
    begin
      if (r_reg.h >= ht - PTG_FIELD_ADD)
      begin
        h_nx = '0;
        v_nx = (r_reg.v >= vt - PTG_FIELD_ADD) ? '0 : r_reg.v + 1'b1;
      end
      else
      begin
        h_nx = r_reg.h + 1'b1;
      end
      r_next.h = h_nx;
      r_next.v = v_nx;
      // Line pulse every line, from start for the width
      r_next.line = (h_nx >= line_pulse_start) && (h_nx < line_pulse_start + line_pulse_width);
      // Frame pulse spans all of line zero
      r_next.frame = (v_nx == '0);
      // Bias flips at line start, a full start position ahead
      if (h_nx == '0)
      begin
        if (ac_bias_lines_cfg == PTG_AC_PER_FRAME)
        begin
          if (v_nx == '0)
          begin
            r_next.ac = !r_reg.ac;
          end
        end
        else if (r_reg.ac_cnt + 1'b1 >= ac_bias_lines_cfg)
        begin
          r_next.ac = !r_reg.ac;
          r_next.ac_cnt = '0;
        end
        else
        begin
          r_next.ac_cnt = r_reg.ac_cnt + 1'b1;
        end
      end
      // Active window; blanking is whatever is left of line or frame
      active = (v_nx < active_lines_per_frame) && (h_nx >= active_start_offset)
        && (h_nx < active_start_offset + active_pixels_per_line);
      rel = h_nx - active_start_offset;
      r_next.sh2 = 1'b0;
      case (mode)
        PTG_MONO8:
        begin
          r_next.sh = active && (rel[2:0] < PTG_MONO8_HIGH);
          load = active && (rel[2:0] == 3'h0);
        end
        PTG_COLOR4:
        begin
          // Held back one pixel at each end of the window
          r_next.sh = active && (rel >= PTG_C4_LEAD)
            && (rel < active_pixels_per_line - PTG_C4_LEAD);
          load = r_next.sh;
        end
        PTG_COLOR8_F1:
        begin
          r_next.sh = active && !rel[1];
          r_next.sh2 = active && rel[1];
          load = active && rel[0];
        end
        default:
        begin
          r_next.sh = active && !rel[0];
          load = active && !rel[0];
        end
      endcase
      if (load)
      begin
        if (out_s.valid)
        begin
          pop = 1'b1;
          if (mode == PTG_COLOR4)
          begin
            r_next.dat = {out_s.data[3:0], 4'h0};
          end
          else
          begin
            r_next.dat = out_s.data;
          end
        end
        else
        begin
          // Missed word keeps the old data on the pins
          r_next.underrun = 1'b1;
        end
      end
      // Pixel counters since each rising edge; line fall lands at spacing
      r_next.lcnt = (r_next.line && !r_reg.line) ? '0
        : r_reg.lcnt + 1'b1;
      r_next.fcnt = (r_next.frame && !r_reg.frame) ? '0
        : r_reg.fcnt + 1'b1;
      r_next.scnt = (r_next.sh && !r_reg.sh) ? '0 : r_reg.scnt + 1'b1;
      if (r_next.line)
      begin
        r_next.line_seen = 1'b1;
      end
    end
    else if (fall && (mode == PTG_COLOR4))
    begin
      r_next.sh = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset || !enable);

  property p_line_start;
    $rose(r_reg.line) |-> (r_reg.h == line_pulse_start);
  endproperty
  a_line_start: assert property (p_line_start)
    else $error("line pulse rose away from its start position");

  property p_line_width;
    $fell(r_reg.line) |-> (r_reg.lcnt == line_pulse_width);
  endproperty
  a_line_width: assert property (p_line_width)
    else $error("line pulse width differs from programmed width");

  property p_line_period;
    $rose(r_reg.line) && $past(r_reg.line_seen)
      |-> ($past(r_reg.lcnt) + PTG_FIELD_ADD == ht);
  endproperty
  a_line_period: assert property (p_line_period)
    else $error("line pulse period differs from pixels per line");

  property p_frame_setup;
    $fell(r_reg.line) && r_reg.frame |-> (r_reg.fcnt == line_pulse_start + line_pulse_width);
  endproperty
  a_frame_setup: assert property (p_frame_setup)
    else $error("frame pulse setup to line fall is wrong");

  property p_frame_hold;
    $fell(r_reg.frame) |-> (r_reg.fcnt == ht);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame pulse hold after line fall is wrong");

  property p_ac_lead;
    $changed(r_reg.ac) |-> (r_reg.h == '0) && !r_reg.line;
  endproperty
  a_ac_lead: assert property (p_ac_lead)
    else $error("bias toggle changed too close to line rise");

  property p_mono_high;
    (mode == PTG_MONO8) && $fell(r_reg.sh)
      |-> (r_reg.scnt == PTG_POS_W'(PTG_MONO8_HIGH));
  endproperty
  a_mono_high: assert property (p_mono_high)
    else $error("mono shift clock high phase is not four pixels");

  property p_c4_half;
    (mode == PTG_COLOR4) && $rose(r_reg.sh) |-> ##[1:6] !r_reg.sh;
  endproperty
  a_c4_half: assert property (p_c4_half)
    else $error("colour four shift clock high longer than half pixel");

  property p_f1_pair;
    (mode == PTG_COLOR8_F1) && $fell(r_reg.sh) && (r_reg.v < active_lines_per_frame)
      && (r_reg.h < active_start_offset + active_pixels_per_line) |-> r_reg.sh2;
  endproperty
  a_f1_pair: assert property (p_f1_pair)
    else $error("second shift clock did not follow the first");

  property p_f2_high;
    (mode == PTG_COLOR8_F2) && $fell(r_reg.sh)
      |-> (r_reg.scnt == PTG_FIELD_ADD);
  endproperty
  a_f2_high: assert property (p_f2_high)
    else $error("format two shift clock high phase is not one pixel");

  property p_blank_quiet;
    (r_reg.v >= active_lines_per_frame) |-> !r_reg.sh && !r_reg.sh2;
  endproperty
  a_blank_quiet: assert property (p_blank_quiet)
    else $error("shift clock ran during vertical blanking");

  property p_first_shift;
    (mode == PTG_MONO8) && $rose(r_reg.sh)
      |-> (r_reg.h >= active_start_offset) && (r_reg.h[2:0] == active_start_offset[2:0]);
  endproperty
  a_first_shift: assert property (p_first_shift)
    else $error("mono shift clock rose off the eight pixel grid");

endmodule : ptg_timing_gen

/* File: dv/ptg_panel_model.sv */
`timescale 1ns/1ps
module ptg_panel_model (
  // Measuring clock
  input wire logic sys_clk,
  // Panel pins
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic shift_clock,
  input wire logic second_shift_clock,
  input wire logic [7:0] panel_data_bus,
  input wire logic ac_bias_toggle,
  // Latched words and spans in sys_clk cycles
  output logic [7:0] word,
  output logic word_stb,
  output logic [15:0] m [0:9]
);
  // Spans are exact only because the pixel period is a whole sys_clk count
  logic [15:0] cyc = 16'h0000;
  logic [15:0] nsh = 16'h0000;
  logic [15:0] act = 16'h0000;
  logic [15:0] t_lr, t_lf, t_fr, t_ac, t_sr, t_sf;
  logic p_l = 1'b0, p_f = 1'b0, p_s = 1'b0, p_s2 = 1'b0, p_a = 1'b0;
  logic seek = 1'b0;

  always @(posedge sys_clk)
  begin
    word_stb <= 1'b0;
    cyc = cyc + 16'h0001;
    if (ac_bias_toggle !== p_a)
      t_ac = cyc;
    if (frame_pulse && !p_f)
    begin
      m[8] <= act;
      act = 16'h0000;
      t_fr = cyc;
    end
    if (line_pulse && !p_l)
    begin
      m[0] <= cyc - t_lr;
      m[3] <= cyc - t_ac;
      t_lr = cyc;
      if (nsh != 16'h0000)
      begin
        m[7] <= nsh;
        m[9] <= cyc - t_sf;
        act = act + 16'h0001;
      end
      nsh = 16'h0000;
    end
    if (!line_pulse && p_l)
    begin
      m[1] <= cyc - t_lr;
      t_lf = cyc;
      seek = 1'b1;
      if (frame_pulse)
        m[2] <= cyc - t_fr;
    end
    if (shift_clock && !p_s)
    begin
      m[6] <= cyc - t_sr;
      t_sr = cyc;
      if (seek)
        m[4] <= cyc - t_lf;
      seek = 1'b0;
    end
    if (!shift_clock && p_s)
      m[5] <= cyc - t_sr;
    // Column drivers latch on the falling edge of either shift clock
    if ((!shift_clock && p_s) || (!second_shift_clock && p_s2))
    begin
      word <= panel_data_bus;
      word_stb <= 1'b1;
      nsh = nsh + 16'h0001;
      t_sf = cyc;
    end
    p_l = line_pulse;
    p_f = frame_pulse;
    p_s = shift_clock;
    p_s2 = second_shift_clock;
    p_a = ac_bias_toggle;
  end
endmodule : ptg_panel_model

/* File: dv/tb_ptg_timing_gen.sv */
`timescale 1ns/1ps
module tb_ptg_timing_gen
  import ptg_pkg::*;
;
  localparam logic [15:0] hi_x [4] = '{16'h0020, 16'h0004, 16'h0010, 16'h0008};
  localparam logic [15:0] per_x [4] = '{16'h0040, 16'h0008, 16'h0020, 16'h0010};
  localparam logic [15:0] wrd_x [4] = '{16'h0004, 16'h001E, 16'h0010, 16'h0010};
  localparam logic [15:0] end_x [4] = '{16'h0030, 16'h001C, 16'h0010, 16'h0018};
  logic sys_clk = 1'b0, reset = 1'b1, pixel_clock = 1'b0, enable = 1'b0;
  ptg_mode_e mode = PTG_MONO8;
  logic [6:0] ht_f = 7'h07, hdp_f = 7'h03, hpw_f = 7'h00;
  logic [9:0] active_start_offset_f = 10'h000, hps_f = 10'h037;
  logic [9:0] vt_f = 10'h002, vdp_f = 10'h001;
  logic [5:0] ac_f = 6'h01;
  logic [7:0] pix_data = 8'h00;
  logic pix_valid = 1'b0, feed = 1'b0, drain = 1'b0;
  logic pix_ready, frame_pulse, line_pulse, shift_clock, second_shift_clock;
  logic ac_bias_toggle, underrun, word_stb;
  logic [7:0] panel_data_bus, word;
  logic [15:0] m [0:9];
  logic [15:0] acc = 16'h0000, w;
  logic [7:0] q [$];
  int error_cnt = 0, checked = 0, n;

  initial forever #12.5 sys_clk = ~sys_clk;
  initial
  begin
    #3;
    forever #100 pixel_clock = ~pixel_clock;
  end

  ptg_timing_gen dut_u (.sys_clk(sys_clk), .reset(reset),
    .pixel_clock(pixel_clock), .enable(enable), .mode(mode),
    .pixels_per_line_cfg(ht_f), .active_pixels_per_line_cfg(hdp_f),
    .active_start_offset_cfg(active_start_offset_f), .line_pulse_start_cfg(hps_f),
    .line_pulse_width_cfg(hpw_f), .lines_per_frame_cfg(vt_f),
    .active_lines_per_frame_cfg(vdp_f), .ac_bias_lines_cfg(ac_f),
    .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .frame_pulse(frame_pulse), .line_pulse(line_pulse),
    .shift_clock(shift_clock), .second_shift_clock(second_shift_clock),
    .panel_data_bus(panel_data_bus), .ac_bias_toggle(ac_bias_toggle),
    .underrun(underrun));

  ptg_panel_model panel_u (.sys_clk(sys_clk), .frame_pulse(frame_pulse),
    .line_pulse(line_pulse), .shift_clock(shift_clock),
    .second_shift_clock(second_shift_clock),
    .panel_data_bus(panel_data_bus), .ac_bias_toggle(ac_bias_toggle),
    .word(word), .word_stb(word_stb), .m(m));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic wait_for(input bit sel, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && (sel ? underrun : pix_ready) !== val; i++)
      @(posedge sys_clk);
    if (i == lim)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : wait_for

  // Source notes each accepted word; colour 4 shows its nibble up high
  always @(posedge sys_clk)
  begin
    if (pix_valid && pix_ready)
    begin
      q.push_back(mode == PTG_COLOR4 ? {pix_data[3:0], 4'h0} : pix_data);
      pix_data <= 8'($urandom);
      acc <= acc + 16'h0001;
    end
    pix_valid <= feed;
  end

  // Repeated stale words after the feed stops are expected, not checked
  always @(posedge sys_clk)
  begin
    if (word_stb && q.size() == 0 && !drain)
      chk(16'h0000, 16'h0001);
    else if (word_stb && q.size() > 0)
      chk({8'h00, word}, {8'h00, q.pop_front()});
  end

  initial
  begin
    n = $urandom(32'hA13A0275);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      reset <= 1'b1;
      enable <= 1'b0;
      feed <= 1'b0;
      drain <= 1'b0;
      mode <= ptg_mode_e'(k);
      hpw_f <= 7'($urandom_range(3));
      ac_f <= 6'(k[0]);
      repeat (2) @(posedge sys_clk);
      q.delete();
      reset <= 1'b0;
      wait_for(1'b0, 1'b1, 10);
      acc <= 16'h0000;
      feed <= 1'b1;
      wait_for(1'b0, 1'b0, 20);
      chk(acc, 16'h0004);
      enable <= 1'b1;
      repeat (3700) @(posedge sys_clk);
      w = 16'(hpw_f) + 16'h0001;
      chk(m[0], 16'h0200);
      chk(m[1], w * 16'h0008);
      chk(m[2], (16'h0038 + w) * 16'h0008);
      chk(m[3], 16'h01C0);
      chk(m[4], (16'h001E - w + 16'(k == 1)) * 16'h0008);
      chk(m[5], hi_x[k]);
      chk(m[6], per_x[k]);
      chk(m[7], wrd_x[k]);
      chk(m[8], 16'h0002);
      chk(m[9], end_x[k]);
      // Three frame starts and eight line starts lie behind this point
      chk({15'h0000, ac_bias_toggle}, 16'(k[0] == 0));
      chk({15'h0000, underrun}, 16'h0000);
      drain <= 1'b1;
      feed <= 1'b0;
      wait_for(1'b1, 1'b1, 2000);
      enable <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk({2'h0, panel_data_bus, ac_bias_toggle, second_shift_clock,
        frame_pulse, line_pulse, shift_clock, underrun}, 16'h0000);
    end
    wrap_up();
  end
endmodule : tb_ptg_timing_gen
